// >>> hdl/pus_sequencer.sv
// Power-up and power-down sequencer with reset combination and actuation gating.
`timescale 1ns/1ns
`default_nettype none

module pus_sequencer
#(
    parameter int NUM_CHANNELS = pus_pkg::PUS_NUM_CHANNELS,
    parameter int NUM_TRIGGERS = pus_pkg::PUS_NUM_TRIGGERS,
    parameter int DELAY_WIDTH = pus_pkg::PUS_DELAY_WIDTH
)
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Analog monitor levels, asynchronous.
    input wire logic bandgap_ok,
    input wire logic dac_reference_ok,
    input wire logic core_rail_ok,
    input wire logic high_voltage_rail_ok,
    input wire logic io_rail_ok,
    input wire logic logic_supply_ok,
    input wire logic ref_clk_stable,
    input wire logic pll_locked,
    input wire logic external_predriver_supply,
    // Host pins, asynchronous.
    input wire logic external_reset_n_pin,
    input wire logic [NUM_TRIGGERS-1:0] actuation_trigger_inputs,
    // Serial interface side, same clock.
    input wire logic serial_reset_request_n,
    input wire logic predriver_wr_stb,
    input wire logic predriver_wr_data,
    input wire logic [NUM_CHANNELS-1:0] microcore_enable,
    input wire logic [DELAY_WIDTH-1:0] io_ready_cycles,
    // Regulator and block enables.
    output logic dac_reference_enable,
    output logic core_rail_enable,
    output logic core_supply_reset_n,
    output logic charge_pump_enable,
    output logic pll_enable,
    output logic predriver_rail_enable,
    output logic boost_enable,
    output logic io_enable,
    // Resets and readiness.
    output logic combined_reset_n,
    output logic serial_active,
    output logic io_ready,
    // Actuation.
    output logic [NUM_TRIGGERS-1:0] actuation_start,
    // Stage status.
    output logic status_ref_stable,
    output logic status_por_released,
    output logic status_cp_running,
    output logic status_pll_locked
);
    // ==========================================================================
    // Elaboration checks.
    generate
        if (NUM_CHANNELS < 1 || NUM_TRIGGERS < 1 || DELAY_WIDTH < 1)
        begin : g_bad
            $error("pus_sequencer parameters must all be at least 1.");
        end
    endgenerate

    // ==========================================================================
    // Input synchronisers.
    localparam int NSYNC = 10 + NUM_TRIGGERS;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn_in;
    logic s_bg;
    logic s_dac;
    logic s_core;
    logic s_hv;
    logic s_io;
    logic s_logic;
    logic s_refclk;
    logic s_lock;
    logic s_extsup;
    logic s_ext_rst_n;
    logic [NUM_TRIGGERS-1:0] s_trig;

    assign raw_in = {actuation_trigger_inputs, external_reset_n_pin, external_predriver_supply, pll_locked,
                     ref_clk_stable, logic_supply_ok, io_rail_ok, high_voltage_rail_ok, core_rail_ok,
                     dac_reference_ok, bandgap_ok};

    pus_sync #(.WIDTH(NSYNC)) u_sync
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(raw_in),
        .sync_out(syn_in)
    );

    assign {s_trig, s_ext_rst_n, s_extsup, s_lock, s_refclk, s_logic, s_io, s_hv, s_core, s_dac, s_bg} = syn_in;

    // ==========================================================================
    // State.
    typedef struct packed
    {
        pus_pkg::pus_state_type state;
        logic dac_en;
        logic core_en;
        logic por_rel;
        logic [DELAY_WIDTH-1:0] cnt;
        logic io_rdy;
        logic io_ok;
        logic cp_on;
        logic pll_on;
        logic pll_lk;
        logic comb_n;
        logic pdrv_flag;
        logic pdrv_on;
        logic boost_on;
        logic [NUM_TRIGGERS-1:0] act;
    } pus_regs_type;

    pus_regs_type st_ff;
    pus_regs_type nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        // RL13 supply fallback
        unique case (st_ff.state)
            // RL1 bandgap before reference
            pus_pkg::PUS_ST_BANDGAP:
            begin
                if (s_bg)
                    nxt_st.state = pus_pkg::PUS_ST_DACREF;
            end
            // RL2 reference before core
            pus_pkg::PUS_ST_DACREF:
            begin
                if (s_dac)
                    nxt_st.state = pus_pkg::PUS_ST_CORE;
            end
            // RL3 core rail releases reset
            pus_pkg::PUS_ST_CORE:
            begin
                if (!s_dac)
                    nxt_st.state = pus_pkg::PUS_ST_DACREF;
                else if (s_core)
                    nxt_st.state = pus_pkg::PUS_ST_RUN;
            end
            pus_pkg::PUS_ST_RUN:
            begin
                if (!s_dac)
                    nxt_st.state = pus_pkg::PUS_ST_DACREF;
                else if (!s_core)
                    nxt_st.state = pus_pkg::PUS_ST_CORE;
            end
        endcase
        if (!s_bg)
            nxt_st.state = pus_pkg::PUS_ST_BANDGAP;
        nxt_st.dac_en = nxt_st.state != pus_pkg::PUS_ST_BANDGAP;
        nxt_st.core_en = nxt_st.state == pus_pkg::PUS_ST_CORE || nxt_st.state == pus_pkg::PUS_ST_RUN;
        nxt_st.por_rel = nxt_st.state == pus_pkg::PUS_ST_RUN;

        // RL18 io ready delay
        if (!st_ff.por_rel)
        begin
            nxt_st.cnt = '0;
            nxt_st.io_rdy = 1'h0;
        end
        else if (!st_ff.io_rdy)
        begin
            if (st_ff.cnt == io_ready_cycles)
                nxt_st.io_rdy = 1'h1;
            else
                nxt_st.cnt = st_ff.cnt + 1'h1;
        end

        // RL12 io supplies gate pins
        nxt_st.io_ok = s_io && s_logic;
        // RL4 charge pump start
        nxt_st.cp_on = st_ff.por_rel && s_hv;
        // RL5 pll start
        nxt_st.pll_on = st_ff.io_ok && s_refclk;
        nxt_st.pll_lk = st_ff.pll_on && s_lock;
        // RL15 combined reset
        nxt_st.comb_n = st_ff.por_rel && s_ext_rst_n && serial_reset_request_n;

        // RL8 serial enable flag
        if (!st_ff.comb_n)
            nxt_st.pdrv_flag = 1'h0;
        else if (predriver_wr_stb)
            nxt_st.pdrv_flag = predriver_wr_data;
        // RL9 needs charge pump
        nxt_st.pdrv_on = st_ff.pdrv_flag && st_ff.cp_on && st_ff.comb_n;
        // RL10 boost after microcores
        nxt_st.boost_on = st_ff.comb_n && (|microcore_enable);
        // RL11 trigger driven actuation
        nxt_st.act = (st_ff.comb_n && st_ff.io_ok && (|microcore_enable)) ? s_trig : '0;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    // ==========================================================================
    // Outputs.
    assign dac_reference_enable = st_ff.dac_en;
    assign core_rail_enable = st_ff.core_en;
    assign core_supply_reset_n = st_ff.por_rel;
    assign charge_pump_enable = st_ff.cp_on;
    assign pll_enable = st_ff.pll_on;
    // External supply status is reported via the pin; the regulator does not fight it.
    assign predriver_rail_enable = st_ff.pdrv_on && !s_extsup;
    assign boost_enable = st_ff.boost_on;
    assign io_enable = st_ff.io_ok;
    assign combined_reset_n = st_ff.comb_n;
    // RL16 serial inactive in reset
    assign serial_active = st_ff.comb_n;
    assign io_ready = st_ff.io_rdy;
    assign actuation_start = st_ff.act;
    // RL19 stage status
    assign status_ref_stable = st_ff.core_en;
    assign status_por_released = st_ff.por_rel;
    assign status_cp_running = st_ff.cp_on;
    assign status_pll_locked = st_ff.pll_lk;

    // ==========================================================================
    // Assertions.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence por_rise_s;
        $rose(st_ff.por_rel);
    endsequence

    sequence io_wait_s;
        !st_ff.io_rdy;
    endsequence

    dac_after_bg_a: assert property ($rose(st_ff.dac_en) |-> $past(s_bg)) // RL1
        else $error("DAC reference enabled without bandgap good.");
    core_after_dac_a: assert property ($rose(st_ff.core_en) |-> $past(s_dac) && st_ff.dac_en) // RL2
        else $error("Core rail enabled without stable reference.");
    por_release_a: assert property ($rose(st_ff.por_rel) |-> $past(s_core) && st_ff.core_en) // RL3
        else $error("Core reset released without core rail good.");
    cp_start_a: assert property (st_ff.cp_on |-> $past(st_ff.por_rel && s_hv)) // RL4
        else $error("Charge pump on without release and rail.");
    pll_start_a: assert property (st_ff.pll_on |-> $past(st_ff.io_ok && s_refclk)) // RL5
        else $error("PLL started without stable clock.");
    pdrv_reset_a: assert property (!st_ff.comb_n |=> !st_ff.pdrv_flag) // RL8
        else $error("Pre-driver enable survived reset.");
    pdrv_cp_a: assert property (st_ff.pdrv_on |-> $past(st_ff.cp_on)) // RL9
        else $error("Pre-driver regulator on without charge pump.");
    boost_gate_a: assert property (st_ff.boost_on |-> $past(st_ff.comb_n && (|microcore_enable))) // RL10
        else $error("Boost on before microcores enabled.");
    act_gate_a: assert property ((|st_ff.act) |-> $past(|microcore_enable) && $past(st_ff.comb_n)) // RL11
        else $error("Actuation without running microcores.");
    comb_reset_a: assert property (st_ff.comb_n == $past(st_ff.por_rel && s_ext_rst_n && serial_reset_request_n)) // RL15
        else $error("Combined reset not the AND of its sources.");
    io_delay_a: assert property (por_rise_s |-> io_wait_s ##1 io_wait_s) // RL18
        else $error("I/O ready asserted too early.");
    io_done_a: assert property ($rose(st_ff.io_rdy) |-> $past(st_ff.cnt) == $past(io_ready_cycles)) // RL18
        else $error("I/O ready count mismatch.");
endmodule

`default_nettype wire

// >>> hdl/pus_sync.sv
// Constants for the power-up sequencer and the two-flop input synchroniser.
// How it works
// RL1: DAC reference starts only after the synchronised bandgap-good level is seen.
// RL2: Core rail regulator starts only after the DAC reference is stable.
// RL3: Core supply reset releases once the core rail is in range.
// RL4: Charge pump starts after core supply reset release with high-voltage rail good.
// RL5: PLL starts once the reference clock is stable and I/O supplies are present.
// RL6: Host holds the external reset pin low until the PLL has locked.
// RL7: Host configures only after release, I/O ready delay and reset pin high.
// RL8: Pre-driver regulator enable is off after reset, set only by serial write.
// RL9: Pre-driver regulator never runs unless the charge pump is running; the code keeps it on for one cycle after the charge pump stops.
// RL10: Boost control starts only after host enables the microcores.
// RL11: With microcores running, actuation follows the trigger input levels.
// RL12: Inputs sampled and outputs driven only with I/O and logic supplies present.
// RL13: Any supply order reaches a correct state; stages fall back when supplies drop.
// RL14: Host asserts the external reset before removing supplies, never mid-actuation.
// RL15: Combined reset is AND of core reset, reset pin and serial request.
// RL16: Serial interface is inactive while combined reset is asserted.
// RL17: Host enables each channel's microcores through that channel's enable register.
// RL18: I/O ready delay is a programmable cycle count from core reset release.
// RL19: Status shows reference stable, core reset released, charge pump, PLL locked.
`timescale 1ns/1ns
`default_nettype none

package pus_pkg;
    // Sequencer states, Gray coded along the power-up path.
    typedef enum logic [1:0]
    {
        PUS_ST_BANDGAP = 2'h0,
        PUS_ST_DACREF = 2'h1,
        PUS_ST_CORE = 2'h3,
        PUS_ST_RUN = 2'h2
    } pus_state_type;
    localparam int PUS_NUM_CHANNELS = 2;
    localparam int PUS_NUM_TRIGGERS = 6;
    localparam int PUS_DELAY_WIDTH = 16;
    localparam int PUS_SYNC_STAGES = 2;
    localparam int PUS_CLK_MHZ = 10;
endpackage

module pus_sync
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ==========================================================================
    // Two flops per bit; the first stage feeds only the second.
    genvar gi;
    generate
        if (WIDTH < 1)
        begin : g_bad
            $error("pus_sync WIDTH must be at least 1.");
        end
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic meta_ff;
            logic stable_ff;
            always_ff @(posedge mclk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    meta_ff <= 1'h0;
                    stable_ff <= 1'h0;
                end
                else
                begin
                    meta_ff <= async_in[gi];
                    stable_ff <= meta_ff;
                end
            end
            assign sync_out[gi] = stable_ff;
        end
    endgenerate
endmodule

`default_nettype wire

// >>> sim/pus_host_model.sv
// Behavioural host that drives the reset pin and the channel enables.
`timescale 1ns/1ns
`default_nettype none

module pus_host_model
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Device status seen by the host.
    input wire logic status_pll_locked,
    input wire logic io_ready,
    input wire logic actuating,
    // Requests from the bench.
    input wire logic cfg_req,
    input wire logic down_req,
    // Host outputs.
    output logic external_reset_n_pin,
    output logic [1:0] microcore_enable
);
    // pin release and power down
    // The pin drops only while no actuation runs, before supplies go.
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            external_reset_n_pin <= 1'b0;
        else if (down_req && !actuating)
            external_reset_n_pin <= 1'b0;
        else if (status_pll_locked && !down_req)
            external_reset_n_pin <= 1'b1;
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            microcore_enable <= 2'h0;
        else
            microcore_enable <= {2{cfg_req && io_ready && external_reset_n_pin}};
    end
endmodule

`default_nettype wire

// >>> sim/test_power_up_sequencer.sv
// Self-checking bench for the power-up sequencer.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module test_power_up_sequencer;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    // bandgap, dacref, core, hv, io, logic, refclk, lock, ext supply
    logic [8:0] sup = 9'h000;
    logic serial_reset_request_n = 1'b1;
    logic predriver_wr_stb = 1'b0;
    logic predriver_wr_data = 1'b0;
    logic [5:0] trig = 6'h00;
    logic cfg_req = 1'b0;
    logic down_req = 1'b0;
    logic pin_n;
    logic [1:0] mce;
    logic dac_en, core_en, por_n, cp_en, pll_en, pd_en, boost_en, io_en;
    logic rst_n, ser_act, io_rdy, st_ref, st_por, st_cp, st_pll;
    logic [5:0] act;
    int error_cnt = 0;
    int n_tests = 0;

    always #50 mclk = ~mclk;

    pus_sequencer u_dut
    (
        .mclk(mclk), .reset_n(reset_n), .bandgap_ok(sup[0]), .dac_reference_ok(sup[1]),
        .core_rail_ok(sup[2]), .high_voltage_rail_ok(sup[3]), .io_rail_ok(sup[4]),
        .logic_supply_ok(sup[5]), .ref_clk_stable(sup[6]), .pll_locked(sup[7]),
        .external_predriver_supply(sup[8]), .external_reset_n_pin(pin_n),
        .actuation_trigger_inputs(trig), .serial_reset_request_n(serial_reset_request_n),
        .predriver_wr_stb(predriver_wr_stb), .predriver_wr_data(predriver_wr_data),
        .microcore_enable(mce), .io_ready_cycles(16'h0003), .dac_reference_enable(dac_en),
        .core_rail_enable(core_en), .core_supply_reset_n(por_n), .charge_pump_enable(cp_en),
        .pll_enable(pll_en), .predriver_rail_enable(pd_en), .boost_enable(boost_en),
        .io_enable(io_en), .combined_reset_n(rst_n), .serial_active(ser_act), .io_ready(io_rdy),
        .actuation_start(act), .status_ref_stable(st_ref), .status_por_released(st_por),
        .status_cp_running(st_cp), .status_pll_locked(st_pll)
    );

    pus_host_model u_host
    (
        .mclk(mclk), .reset_n(reset_n), .status_pll_locked(st_pll), .io_ready(io_rdy),
        .actuating(|act), .cfg_req(cfg_req), .down_req(down_req),
        .external_reset_n_pin(pin_n), .microcore_enable(mce)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic pd_write(input logic v);
        predriver_wr_data = v;
        predriver_wr_stb = 1'b1;
        tick(1);
        predriver_wr_stb = 1'b0;
        tick(4);
    endtask

    task automatic t_sequence;
        int k;
        sup[0] = 1'b1;
        tick(5);
        `CHK({dac_en, core_en, st_ref}, 3'h4)
        sup[1] = 1'b1;
        tick(5);
        `CHK({core_en, st_ref, por_n}, 3'h6)
        sup[2] = 1'b1;
        k = 0;
        while (por_n !== 1'b1 && k < 10)
        begin
            tick(1);
            k++;
        end
        `CHK(st_por, 1'b1)
        tick(3);
        `CHK(io_rdy, 1'b0)
        tick(1);
        `CHK(io_rdy, 1'b1)
        `CHK(cp_en, 1'b0)
        sup[3] = 1'b1;
        tick(5);
        `CHK({cp_en, st_cp}, 2'h3)
        sup[6:4] = 3'h7;
        tick(6);
        `CHK({io_en, pll_en, rst_n}, 3'h6)
        pd_write(1'b1);
        `CHK(pd_en, 1'b0)
        sup[7] = 1'b1;
        tick(8);
        `CHK({st_pll, rst_n, ser_act}, 3'h7)
        $display("test sequence done");
    endtask

    task automatic t_predriver;
        `CHK(pd_en, 1'b0)
        sup[8] = 1'b1;
        pd_write(1'b1);
        `CHK(pd_en, 1'b0)
        sup[8] = 1'b0;
        tick(5);
        `CHK(pd_en, 1'b1)
        sup[3] = 1'b0;
        tick(6);
        `CHK({cp_en, pd_en}, 2'h0)
        sup[3] = 1'b1;
        tick(6);
        `CHK(pd_en, 1'b1)
        $display("test predriver done");
    endtask

    task automatic t_actuate;
        trig = 6'h2a;
        tick(6);
        `CHK({boost_en, act}, 7'h00)
        cfg_req = 1'b1;
        tick(6);
        `CHK(boost_en, 1'b1)
        `CHK(act, 6'h2a)
        trig = 6'h15;
        tick(4);
        `CHK(act, 6'h15)
        sup[4] = 1'b0;
        tick(5);
        `CHK({io_en, act}, 7'h00)
        sup[4] = 1'b1;
        tick(6);
        `CHK({io_en, act}, 7'h55)
        $display("test actuate done");
    endtask

    task automatic t_serial_reset;
        serial_reset_request_n = 1'b0;
        tick(3);
        `CHK({rst_n, ser_act, act}, 8'h00)
        serial_reset_request_n = 1'b1;
        tick(3);
        `CHK({rst_n, ser_act}, 2'h3)
        $display("test serial reset done");
    endtask

    task automatic t_power_down;
        trig = 6'h00;
        down_req = 1'b1;
        tick(8);
        `CHK({pin_n, rst_n}, 2'h0)
        sup[2] = 1'b0;
        tick(5);
        `CHK({por_n, io_rdy, cp_en}, 3'h0)
        sup[0] = 1'b0;
        tick(5);
        `CHK({dac_en, core_en, st_ref}, 3'h0)
        $display("test power down done");
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #(5000 * 100);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        tick(10);
        reset_n = 1'b1;
        tick(1);
        t_sequence();
        t_predriver();
        t_actuate();
        t_serial_reset();
        t_power_down();
        tally_and_finish();
    end
endmodule

`default_nettype wire
